// file: src/qwi_pkg.sv
// Constants and types for the transmit queue watermark and interrupt block
// Overview of operation
// R1 - Enable bit 3 passes the SAPI-high mismatch flag onto the interrupt.
// R2 - Enable bit 2 passes the SAPI-low mismatch flag onto the interrupt.
// R3 - Enable bit 1 passes the control-field mismatch flag onto the interrupt.
// R4 - Enable bit 0 passes the address-field mismatch flag onto the interrupt.
// R5 - Low watermark byte position is low mark times 32 times 2048.
// R6 - High watermark byte position is high mark times 32 times 2048.
// R7 - Watched queue holds serial-side data waiting for the Ethernet side.
// R8 - Enable bit 3 passes the FIFO overflow flag onto the watermark interrupt.
// R9 - Enable bit 2 passes the queue overflow flag onto the watermark interrupt.
// R10 - Enable bit 1 passes the high crossing flag onto the watermark interrupt.
// R11 - Enable bit 0 passes the low crossing flag onto the watermark interrupt.
// R12 - Bit 3 latches receive-to-memory FIFO overflow; cleared after host read.
// R13 - Bit 2 latches transmit queue overflow; cleared after host read.
// R14 - Bit 1 latches a high watermark crossing; cleared after host read.
// R15 - Bit 0 latches a low watermark crossing; cleared after host read.
// R16 - SAPI octet differing from its expected value latches a flag, cleared on read.
// R17 - Address or control differing from expected latches a flag, cleared on read.
// R18 - Interrupt is the OR of enabled latched flags, dropping once all clear.
// R19 - Crossings are seen by comparing on each fill change, latching transitions only.
package qwi_pkg;

  localparam int ADDR_W = 9;
  localparam int DATA_W = 8;

  // Register offsets on the parallel port
  localparam logic [8:0] OFS_HDR_STATUS = 9'h122;
  localparam logic [8:0] OFS_HDR_IRQ_EN = 9'h123;
  localparam logic [8:0] OFS_LOW_MARK   = 9'h124;
  localparam logic [8:0] OFS_HIGH_MARK  = 9'h125;
  localparam logic [8:0] OFS_TXQ_IRQ_EN = 9'h126;
  localparam logic [8:0] OFS_TXQ_STATUS = 9'h127;

  // Field positions, shared by status and enable registers
  localparam int BIT_ADDRESS = 0;
  localparam int BIT_CONTROL = 1;
  localparam int BIT_SAPI_LO = 2;
  localparam int BIT_SAPI_HI = 3;
  localparam int BIT_LOW     = 0;
  localparam int BIT_HIGH    = 1;
  localparam int BIT_QOVF    = 2;
  localparam int BIT_FOVF    = 3;
  localparam int EVT_W       = 4;

  // One mark step is 32 packets of 2048 bytes, a shift of 16
  localparam int MARK_PACKETS = 32;
  localparam int PACKET_BYTES = 2048;
  localparam int MARK_SHIFT   = $clog2(MARK_PACKETS * PACKET_BYTES);
  localparam int MIN_FILL_W   = DATA_W + MARK_SHIFT;

  localparam logic [7:0] RST_REG = 8'h00;

  typedef struct packed {
    logic [7:0] address;
    logic [7:0] control;
    logic [7:0] sapi_high;
    logic [7:0] sapi_low;
  } qwi_hdr_t;

endpackage : qwi_pkg

// file: src/qwi_top.sv
// Watermark, overflow and header mismatch status with interrupt enables
`timescale 1ns/100ps
module qwi_top #(
  parameter int FILL_W = 24
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  nrst,
  // Parallel register port
  input  wire logic [8:0]            reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // Received header check
  input  wire logic                  hdr_valid,
  input  wire qwi_pkg::qwi_hdr_t     hdr_rx,
  input  wire qwi_pkg::qwi_hdr_t     hdr_expected,
  // Transmit queue events
  input  wire logic [FILL_W-1:0]     txq_fill,
  input  wire logic                  txq_overflow,
  input  wire logic                  fifo_overflow,
  // Interrupts
  output logic                       hdr_irq,
  output logic                       watermark_irq,
  output logic                       irq
);

  if (FILL_W < qwi_pkg::MIN_FILL_W) begin : g_fill_check
    $error("qwi_top: FILL_W too narrow for the watermark positions");
  end

  // Reset release synchroniser
  logic       rst_meta_ff;
  logic       rst_sync_ff;
  logic       rst_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  assign rst_n = rst_sync_ff;

  // Register port decode
  logic       rd_hdr_status;
  logic       rd_txq_status;

  assign rd_hdr_status = reg_rd && (reg_addr == qwi_pkg::OFS_HDR_STATUS);
  assign rd_txq_status = reg_rd && (reg_addr == qwi_pkg::OFS_TXQ_STATUS);

  // Software control registers
  logic [7:0] hdr_irq_en_ff;
  logic [7:0] low_mark_ff;
  logic [7:0] high_mark_ff;
  logic [7:0] txq_irq_en_ff;
  logic [7:0] nxt_hdr_irq_en;
  logic [7:0] nxt_low_mark;
  logic [7:0] nxt_high_mark;
  logic [7:0] nxt_txq_irq_en;

  always_comb begin
    nxt_hdr_irq_en = hdr_irq_en_ff;
    nxt_low_mark   = low_mark_ff;
    nxt_high_mark  = high_mark_ff;
    nxt_txq_irq_en = txq_irq_en_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        qwi_pkg::OFS_HDR_IRQ_EN: nxt_hdr_irq_en = reg_wdata;
        qwi_pkg::OFS_LOW_MARK:   nxt_low_mark   = reg_wdata;
        qwi_pkg::OFS_HIGH_MARK:  nxt_high_mark  = reg_wdata;
        qwi_pkg::OFS_TXQ_IRQ_EN: nxt_txq_irq_en = reg_wdata;
        // Status and unmapped offsets ignore writes
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_irq_en_ff <= qwi_pkg::RST_REG;
      low_mark_ff   <= qwi_pkg::RST_REG;
      high_mark_ff  <= qwi_pkg::RST_REG;
      txq_irq_en_ff <= qwi_pkg::RST_REG;
    end else begin
      hdr_irq_en_ff <= nxt_hdr_irq_en;
      low_mark_ff   <= nxt_low_mark;
      high_mark_ff  <= nxt_high_mark;
      txq_irq_en_ff <= nxt_txq_irq_en;
    end
  end

  // Watermark positions in bytes of the serial-to-Ethernet queue
  logic [FILL_W-1:0] low_pos;
  logic [FILL_W-1:0] high_pos;

  assign low_pos  = FILL_W'({low_mark_ff, {qwi_pkg::MARK_SHIFT{1'b0}}});  // [R5] [R7]
  assign high_pos = FILL_W'({high_mark_ff, {qwi_pkg::MARK_SHIFT{1'b0}}}); // [R6] [R7]

  // Crossing detector state
  logic [FILL_W-1:0] fill_ff;
  logic              above_low_ff;
  logic              above_high_ff;
  logic [FILL_W-1:0] nxt_fill;
  logic              nxt_above_low;
  logic              nxt_above_high;
  logic              fill_changed;
  logic              low_cross;
  logic              high_cross;

  always_comb begin
    nxt_fill       = txq_fill;
    fill_changed   = (txq_fill != fill_ff);
    nxt_above_low  = above_low_ff;
    nxt_above_high = above_high_ff;
    // Compare only when the fill moves; a mark rewrite alone raises no event
    if (fill_changed) begin
      nxt_above_low  = (txq_fill >= low_pos);  // [R19]
      nxt_above_high = (txq_fill >= high_pos); // [R19]
    end
    low_cross  = fill_changed && (nxt_above_low != above_low_ff);   // [R19]
    high_cross = fill_changed && (nxt_above_high != above_high_ff); // [R19]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fill_ff       <= '0;
      above_low_ff  <= 1'b1;
      above_high_ff <= 1'b1;
    end else begin
      fill_ff       <= nxt_fill;
      above_low_ff  <= nxt_above_low;
      above_high_ff <= nxt_above_high;
    end
  end

  // Header mismatch comparison
  logic [qwi_pkg::EVT_W-1:0] hdr_event;

  always_comb begin
    hdr_event = '0;
    if (hdr_valid) begin
      hdr_event[qwi_pkg::BIT_SAPI_HI] = hdr_rx.sapi_high != hdr_expected.sapi_high; // [R16]
      hdr_event[qwi_pkg::BIT_SAPI_LO] = hdr_rx.sapi_low != hdr_expected.sapi_low;   // [R16]
      hdr_event[qwi_pkg::BIT_CONTROL] = hdr_rx.control != hdr_expected.control;     // [R17]
      hdr_event[qwi_pkg::BIT_ADDRESS] = hdr_rx.address != hdr_expected.address;     // [R17]
    end
  end

  // Queue events
  logic [qwi_pkg::EVT_W-1:0] txq_event;

  always_comb begin
    txq_event                    = '0;
    txq_event[qwi_pkg::BIT_FOVF] = fifo_overflow; // [R12]
    txq_event[qwi_pkg::BIT_QOVF] = txq_overflow;  // [R13]
    txq_event[qwi_pkg::BIT_HIGH] = high_cross;    // [R14]
    txq_event[qwi_pkg::BIT_LOW]  = low_cross;     // [R15]
  end

  // Latched status, cleared by reading; a same-cycle event survives the read
  logic [qwi_pkg::EVT_W-1:0] hdr_status_ff;
  logic [qwi_pkg::EVT_W-1:0] txq_status_ff;
  logic [qwi_pkg::EVT_W-1:0] nxt_hdr_status;
  logic [qwi_pkg::EVT_W-1:0] nxt_txq_status;

  always_comb begin
    nxt_hdr_status = hdr_status_ff;
    nxt_txq_status = txq_status_ff;
    if (rd_hdr_status) begin
      nxt_hdr_status = '0; // [R16] [R17]
    end
    if (rd_txq_status) begin
      nxt_txq_status = '0; // [R12] [R13] [R14] [R15]
    end
    nxt_hdr_status = nxt_hdr_status | hdr_event; // [R16] [R17]
    nxt_txq_status = nxt_txq_status | txq_event; // [R12] [R13] [R14] [R15]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_status_ff <= '0;
      txq_status_ff <= '0;
    end else begin
      hdr_status_ff <= nxt_hdr_status;
      txq_status_ff <= nxt_txq_status;
    end
  end

  // Named views of the flags and enables, in the terms software uses
  logic       sapi_high_mismatch_flag;
  logic       sapi_low_mismatch_flag;
  logic       control_mismatch_flag;
  logic       address_mismatch_flag;
  logic       fifo_overflow_latched;
  logic       queue_overflow_latched;
  logic       high_mark_latched;
  logic       low_mark_latched;
  logic       sapi_high_mismatch_irq_en;
  logic       sapi_low_mismatch_irq_en;
  logic       control_mismatch_irq_en;
  logic       address_mismatch_irq_en;
  logic       fifo_overflow_irq_en;
  logic       queue_overflow_irq_en;
  logic       high_mark_irq_en;
  logic       low_mark_irq_en;

  assign sapi_high_mismatch_flag   = hdr_status_ff[qwi_pkg::BIT_SAPI_HI];
  assign sapi_low_mismatch_flag    = hdr_status_ff[qwi_pkg::BIT_SAPI_LO];
  assign control_mismatch_flag     = hdr_status_ff[qwi_pkg::BIT_CONTROL];
  assign address_mismatch_flag     = hdr_status_ff[qwi_pkg::BIT_ADDRESS];
  assign fifo_overflow_latched     = txq_status_ff[qwi_pkg::BIT_FOVF];
  assign queue_overflow_latched    = txq_status_ff[qwi_pkg::BIT_QOVF];
  assign high_mark_latched         = txq_status_ff[qwi_pkg::BIT_HIGH];
  assign low_mark_latched          = txq_status_ff[qwi_pkg::BIT_LOW];
  assign sapi_high_mismatch_irq_en = hdr_irq_en_ff[qwi_pkg::BIT_SAPI_HI];
  assign sapi_low_mismatch_irq_en  = hdr_irq_en_ff[qwi_pkg::BIT_SAPI_LO];
  assign control_mismatch_irq_en   = hdr_irq_en_ff[qwi_pkg::BIT_CONTROL];
  assign address_mismatch_irq_en   = hdr_irq_en_ff[qwi_pkg::BIT_ADDRESS];
  assign fifo_overflow_irq_en      = txq_irq_en_ff[qwi_pkg::BIT_FOVF];
  assign queue_overflow_irq_en     = txq_irq_en_ff[qwi_pkg::BIT_QOVF];
  assign high_mark_irq_en          = txq_irq_en_ff[qwi_pkg::BIT_HIGH];
  assign low_mark_irq_en           = txq_irq_en_ff[qwi_pkg::BIT_LOW];

  // Interrupt gating, one term per status bit
  logic [qwi_pkg::EVT_W-1:0] hdr_gated;
  logic [qwi_pkg::EVT_W-1:0] txq_gated;

  for (genvar i = 0; i < qwi_pkg::EVT_W; i++) begin : g_gate
    // Bits 3..0 of each enable steer the same-numbered status bit
    assign hdr_gated[i] = nxt_hdr_status[i] & nxt_hdr_irq_en[i]; // [R1] [R2] [R3] [R4]
    assign txq_gated[i] = nxt_txq_status[i] & nxt_txq_irq_en[i]; // [R8] [R9] [R10] [R11]
  end

  logic hdr_irq_ff;
  logic wm_irq_ff;
  logic nxt_hdr_irq;
  logic nxt_wm_irq;
  logic irq_ff;
  logic nxt_irq;

  always_comb begin
    nxt_hdr_irq = |hdr_gated; // [R18]
    nxt_wm_irq  = |txq_gated; // [R18]
    nxt_irq     = nxt_hdr_irq | nxt_wm_irq; // [R18]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr_irq_ff <= 1'b0;
      wm_irq_ff  <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      hdr_irq_ff <= nxt_hdr_irq;
      wm_irq_ff  <= nxt_wm_irq;
      irq_ff     <= nxt_irq;
    end
  end

  assign hdr_irq       = hdr_irq_ff;
  assign watermark_irq = wm_irq_ff;
  assign irq           = irq_ff; // [R18]

  // Read data, registered; the value shown is the one before the clear
  logic [7:0] rdata_ff;
  logic [7:0] nxt_rdata;

  always_comb begin
    nxt_rdata = rdata_ff;
    if (reg_rd) begin
      unique case (reg_addr)
        qwi_pkg::OFS_HDR_STATUS: nxt_rdata = {4'h0, sapi_high_mismatch_flag,
                                              sapi_low_mismatch_flag,
                                              control_mismatch_flag,
                                              address_mismatch_flag};
        qwi_pkg::OFS_HDR_IRQ_EN: nxt_rdata = {hdr_irq_en_ff[7:4],
                                              sapi_high_mismatch_irq_en,
                                              sapi_low_mismatch_irq_en,
                                              control_mismatch_irq_en,
                                              address_mismatch_irq_en};
        qwi_pkg::OFS_LOW_MARK:   nxt_rdata = low_mark_ff;
        qwi_pkg::OFS_HIGH_MARK:  nxt_rdata = high_mark_ff;
        qwi_pkg::OFS_TXQ_IRQ_EN: nxt_rdata = {txq_irq_en_ff[7:4],
                                              fifo_overflow_irq_en,
                                              queue_overflow_irq_en,
                                              high_mark_irq_en,
                                              low_mark_irq_en};
        qwi_pkg::OFS_TXQ_STATUS: nxt_rdata = {4'h0, fifo_overflow_latched,
                                              queue_overflow_latched,
                                              high_mark_latched,
                                              low_mark_latched};
        default:                 nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= qwi_pkg::RST_REG;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

endmodule // qwi_top

// file: verif/qwi_sva.sv
// Assertion checker for the qwi_top ports
`timescale 1ns/100ps
module qwi_sva #(
  parameter int FILL_W = 24
) (
  // Clock, reset and register port
  input wire logic              clk,
  input wire logic              nrst,
  input wire logic [8:0]        reg_addr,
  input wire logic [7:0]        reg_wdata,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  // Events and interrupts
  input wire logic              hdr_valid,
  input wire qwi_pkg::qwi_hdr_t hdr_rx,
  input wire qwi_pkg::qwi_hdr_t hdr_expected,
  input wire logic [FILL_W-1:0] txq_fill,
  input wire logic              txq_overflow,
  input wire logic              fifo_overflow,
  input wire logic              hdr_irq,
  input wire logic              watermark_irq,
  input wire logic              irq
);
  logic [3:0] hen_ff;
  logic [3:0] ten_ff;
  // Enable shadows, so each event can be tied to what the host enabled
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) hen_ff <= 4'h0;
    else if (reg_wr && reg_addr == 9'h123) hen_ff <= reg_wdata[3:0];
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) ten_ff <= 4'h0;
    else if (reg_wr && reg_addr == 9'h126) ten_ff <= reg_wdata[3:0];
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  irq_or_a:
    assert property (irq == (hdr_irq | watermark_irq)) else $error("irq not OR");
  fovf_irq_a:
    assert property (fifo_overflow && ten_ff[3] && !reg_wr |=> watermark_irq)
      else $error("fifo overflow no irq");
  qovf_irq_a:
    assert property (txq_overflow && ten_ff[2] && !reg_wr |=> watermark_irq)
      else $error("queue overflow no irq");
  addr_mis_a:
    assert property (hdr_valid && hen_ff[0] && !reg_wr
      && hdr_rx.address != hdr_expected.address |=> hdr_irq) else $error("address no irq");
  sapi_hi_a:
    assert property (hdr_valid && hen_ff[3] && !reg_wr
      && hdr_rx.sapi_high != hdr_expected.sapi_high |=> hdr_irq) else $error("sapi no irq");
  sapi_lo_a:
    assert property (hdr_valid && hen_ff[2] && !reg_wr
      && hdr_rx.sapi_low != hdr_expected.sapi_low |=> hdr_irq) else $error("sapi low no irq");
  ctrl_mis_a:
    assert property (hdr_valid && hen_ff[1] && !reg_wr
      && hdr_rx.control != hdr_expected.control |=> hdr_irq) else $error("control no irq");
  hdr_cause_a:
    assert property ($rose(hdr_irq) |-> $past(hdr_valid | reg_wr)) else $error("hdr irq rose");
  wm_cause_a:
    assert property ($rose(watermark_irq) |-> $past(fifo_overflow | txq_overflow | reg_wr)
      || $past(txq_fill) != $past(txq_fill, 2)) else $error("watermark irq rose");
  rd_clear_a:
    assert property (reg_rd && reg_addr == 9'h127 && !reg_wr && !fifo_overflow
      && !txq_overflow && $stable(txq_fill) |=> !watermark_irq) else $error("no clear");
  c_fovf: cover property (fifo_overflow && ten_ff[3]);
  c_hdr: cover property ($rose(hdr_irq));
  c_clr: cover property (reg_rd && reg_addr == 9'h127 && watermark_irq);
endmodule // qwi_sva
bind qwi_top qwi_sva #(.FILL_W(FILL_W)) u_sva (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .hdr_valid(hdr_valid),
  .hdr_rx(hdr_rx), .hdr_expected(hdr_expected), .txq_fill(txq_fill),
  .txq_overflow(txq_overflow), .fifo_overflow(fifo_overflow), .hdr_irq(hdr_irq),
  .watermark_irq(watermark_irq), .irq(irq));

// file: verif/qwi_host.sv
// Host processor model on the register port
`timescale 1ns/100ps
module qwi_host (
  // Clock
  input wire logic        clk,
  // Register port
  output logic [8:0]      reg_addr = 9'h000,
  output logic [7:0]      reg_wdata = 8'h00,
  output logic            reg_wr = 1'b0,
  output logic            reg_rd = 1'b0,
  input wire logic [7:0]  reg_rdata
);
  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    // Stale data must not look valid
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [8:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
endmodule // qwi_host

// file: verif/qwi_top_test.sv
// Self-checking bench for qwi_top
`timescale 1ns/100ps
module qwi_top_test;
  logic              clk = 1'b0;
  logic              nrst = 1'b0;
  logic              hdr_valid = 1'b0;
  logic              txq_overflow = 1'b0;
  logic              fifo_overflow = 1'b0;
  logic [23:0]       txq_fill = 24'h000000;
  qwi_pkg::qwi_hdr_t hdr_expected = 32'h5A3CC35A;
  qwi_pkg::qwi_hdr_t hdr_rx = 32'h5A3CC35A;
  logic [8:0]        reg_addr;
  logic [7:0]        reg_wdata, reg_rdata, rv;
  logic              reg_wr, reg_rd, hdr_irq, watermark_irq, irq;
  int                fail_count = 0;
  int                n_tests = 0;
  int                cyc = 0;
  qwi_top #(.FILL_W(24)) dut (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hdr_valid(hdr_valid), .hdr_rx(hdr_rx), .hdr_expected(hdr_expected), .txq_fill(txq_fill),
    .txq_overflow(txq_overflow), .fifo_overflow(fifo_overflow), .hdr_irq(hdr_irq),
    .watermark_irq(watermark_irq), .irq(irq));
  qwi_host host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk(rv, exp);
  endtask
  task automatic setfill(input logic [23:0] v);
    @(posedge clk);
    txq_fill <= v;
    @(posedge clk);
    #1;
  endtask
  task automatic evt(input logic f, input logic q);
    @(posedge clk);
    fifo_overflow <= f;
    txq_overflow <= q;
    @(posedge clk);
    fifo_overflow <= 1'b0;
    txq_overflow <= 1'b0;
    #1;
  endtask
  task automatic t_regs;
    for (int i = 2; i < 8; i++) rdchk(9'h120 + 9'(i), 8'h00);
    rdchk(9'h1FF, 8'h00);
    host.wr(9'h123, 8'h0A);
    host.wr(9'h124, 8'hC3);
    host.wr(9'h125, 8'h3C);
    host.wr(9'h126, 8'h05);
    host.wr(9'h127, 8'hFF);
    rdchk(9'h123, 8'h0A);
    rdchk(9'h124, 8'hC3);
    rdchk(9'h125, 8'h3C);
    rdchk(9'h126, 8'h05);
    rdchk(9'h127, 8'h00);
  endtask
  task automatic t_marks;
    host.wr(9'h124, 8'h01);
    host.wr(9'h125, 8'h02);
    host.wr(9'h126, 8'h03);
    setfill(24'h00FFFF);
    rdchk(9'h127, 8'h03);
    setfill(24'h010000);
    chk({7'h0, watermark_irq}, 8'h01);
    rdchk(9'h127, 8'h01);
    setfill(24'h01FFFF);
    rdchk(9'h127, 8'h00);
    setfill(24'h020000);
    chk({7'h0, irq}, 8'h01);
    rdchk(9'h127, 8'h02);
    setfill(24'h00FFFF);
    rdchk(9'h127, 8'h03);
    chk({7'h0, watermark_irq}, 8'h00);
  endtask
  task automatic t_ovf;
    host.wr(9'h126, 8'h08);
    evt(1'b1, 1'b0);
    chk({6'h0, watermark_irq, irq}, 8'h03);
    rdchk(9'h127, 8'h08);
    evt(1'b0, 1'b1);
    chk({7'h0, watermark_irq}, 8'h00);
    rdchk(9'h127, 8'h04);
    host.wr(9'h126, 8'h04);
    evt(1'b0, 1'b1);
    chk({7'h0, watermark_irq}, 8'h01);
    rdchk(9'h127, 8'h04);
  endtask
  task automatic t_hdr;
    int pos [4] = '{24, 16, 0, 8};
    for (int i = 0; i < 4; i++) begin
      host.wr(9'h123, 8'(1 << i));
      @(posedge clk);
      hdr_rx <= qwi_pkg::qwi_hdr_t'(hdr_expected ^ (32'h1 << pos[i]));
      hdr_valid <= 1'b1;
      @(posedge clk);
      hdr_valid <= 1'b0;
      hdr_rx <= qwi_pkg::qwi_hdr_t'(~hdr_rx);
      #1;
      chk({7'h0, hdr_irq}, 8'h01);
      rdchk(9'h122, 8'(1 << i));
      chk({7'h0, irq}, 8'h00);
    end
  endtask
  task automatic summarize;
    if (fail_count == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    repeat (2) @(posedge clk);
    t_regs();
    t_marks();
    t_ovf();
    t_hdr();
    summarize();
  end
endmodule // qwi_top_test
